// *** src/mfd_cfg.svh ***
// Functional notes
// (R1) sixteen 2-bit domain permission fields, domain 15 in the top bits
// (R2) permission 00 denies the access and raises a domain fault
// (R3) permission 01 checks page or section permission bits
// (R4) permission 10 is reserved and behaves like no access
// (R5) permission 11 grants access without checking permission bits
// (R6) any domain register write invalidates all unlocked TLB entries
// (R7) software re-invalidates and reloads a locked entry after changing its domain
// (R8) any transfer to coprocessor register 4 is an undefined instruction
// (R9) data fault status bits 7:4 record the faulting domain
// (R10) fault status bits 3:0 hold the documented fault type code
// (R11) simultaneous faults report the highest priority type only
// (R12) first-level walk abort 1100 no domain; second-level 1110 with domain
// (R13) data status captures data aborts and watchpoints; debug event as watchpoint
// (R14) instruction status captures prefetch aborts and breakpoints, upper bits zero
// (R15) data status write replaces contents; read returns contents
// (R16) instruction status write replaces contents; read returns contents
// (R17) software updates status registers read-modify-write, zero in bits 31:8
// (R18) software sets the minor register field to zero for these registers
// (R19) fault address read: secondary opcode 0 data, 1 instruction
// (R20) a fault address write loads the written 32-bit value
// (R21) data fault address captures the aborting or watchpoint access address
// (R22) instruction fault address is pc plus 8, or plus 4 in 16-bit state
// (R23) status and address registers change only on taken events or writes
`ifndef MFD_CFG_SVH
`define MFD_CFG_SVH
`define MFD_CRN_DOMAIN 4'h3
`define MFD_CRN_RSVD 4'h4
`define MFD_CRN_STATUS 4'h5
`define MFD_CRN_ADDR 4'h6
`define MFD_DOM_LSB 4
`define MFD_DOM_MSB 7
`define MFD_FS_ALIGN 4'h1
`define MFD_FS_TLBMISS 4'h0
`define MFD_FS_EXT_L1 4'hc
`define MFD_FS_EXT_L2 4'he
`define MFD_FS_TR_SEC 4'h5
`define MFD_FS_TR_PAGE 4'h7
`define MFD_FS_DOM_SEC 4'h9
`define MFD_FS_DOM_PAGE 4'hb
`define MFD_FS_PERM_SEC 4'hd
`define MFD_FS_PERM_PAGE 4'hf
`define MFD_FS_EXT 4'ha
`define MFD_FS_DEBUG 4'h2
`define MFD_PC_OFS_32 32'h0000_0008
`define MFD_PC_OFS_16 32'h0000_0004
`define MFD_RST_REG 32'h0000_0000
`endif

// *** src/mfd_pkg.sv ***
`default_nettype none
package mfd_pkg;
  typedef enum logic [1:0] {
    MFD_DOM_NONE,
    MFD_DOM_CLIENT,
    MFD_DOM_RSVD,
    MFD_DOM_MANAGER
  } mfd_dom_perm_t;
  typedef logic [3:0] mfd_fault_code_t;
  typedef logic [31:0] mfd_word_t;
endpackage : mfd_pkg
`default_nettype wire

// *** src/mfd_regs.sv ***
`include "mfd_cfg.svh"
`default_nettype none
module mfd_regs
  import mfd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  // coprocessor register transfer
  input wire logic i_cp_valid,
  input wire logic i_cp_write,
  input wire logic [3:0] i_cp_crn,
  input wire logic [3:0] i_cp_crm,
  input wire logic [2:0] i_cp_op2,
  input wire logic [31:0] i_cp_wdata,
  output logic [31:0] o_cp_rdata,
  output logic o_cp_undef,
  // access check for the current translated access
  input wire logic i_chk_valid,
  input wire logic [3:0] i_chk_domain,
  input wire logic i_chk_page,
  input wire logic i_chk_perm_ok,
  output logic o_chk_domain_fault,
  output logic o_chk_check_perm,
  output logic o_chk_grant,
  output logic [3:0] o_chk_code,
  // data abort / watchpoint report
  input wire logic i_dabt_take,
  input wire logic i_dabt_align,
  input wire logic i_dabt_tlbmiss,
  input wire logic i_dabt_ext_l1,
  input wire logic i_dabt_ext_l2,
  input wire logic i_dabt_trans,
  input wire logic i_dabt_domain,
  input wire logic i_dabt_perm,
  input wire logic i_dabt_page,
  input wire logic i_dabt_ext,
  input wire logic i_dabt_debug,
  input wire logic [3:0] i_dabt_dom,
  input wire logic [31:0] i_dabt_va,
  // prefetch abort / breakpoint report; unlocked TLB flush on domain write
  input wire logic i_pabt_take,
  input wire logic [3:0] i_pabt_code,
  input wire logic i_pabt_debug,
  input wire logic [31:0] i_pabt_pc,
  input wire logic i_pabt_narrow,
  output logic o_tlb_flush_unlocked
);

  logic [31:0] dom_q;
  logic [31:0] data_fault_cause_q;
  logic [31:0] instruction_fault_cause_q;
  logic [31:0] dfar_q;
  logic [31:0] ifar_q;
  logic [3:0] dcode;
  logic dom_ok;
  mfd_dom_perm_t perm;

  wire wr = i_cp_valid && i_cp_write;
  wire sel_dom = i_cp_crn == `MFD_CRN_DOMAIN;
  wire sel_fs = i_cp_crn == `MFD_CRN_STATUS;
  wire sel_fa = i_cp_crn == `MFD_CRN_ADDR;
  wire op_i = i_cp_op2[0];

  assign o_cp_undef = i_cp_valid && (i_cp_crn == `MFD_CRN_RSVD); // R8

  // domain permission lookup
  always_comb begin
    perm = mfd_dom_perm_t'(dom_q[{i_chk_domain, 1'b0} +: 2]); // R1
    o_chk_domain_fault = 1'b0;
    o_chk_check_perm = 1'b0;
    o_chk_grant = 1'b0;
    unique case (perm)
      MFD_DOM_NONE: o_chk_domain_fault = i_chk_valid; // R2
      MFD_DOM_CLIENT: begin
        o_chk_check_perm = i_chk_valid; // R3
        o_chk_grant = i_chk_valid && i_chk_perm_ok;
      end
      MFD_DOM_RSVD: o_chk_domain_fault = i_chk_valid; // R4
      MFD_DOM_MANAGER: o_chk_grant = i_chk_valid; // R5
    endcase
    if (o_chk_domain_fault) begin
      o_chk_code = i_chk_page ? `MFD_FS_DOM_PAGE : `MFD_FS_DOM_SEC;
    end else if (o_chk_check_perm && !i_chk_perm_ok) begin
      o_chk_code = i_chk_page ? `MFD_FS_PERM_PAGE : `MFD_FS_PERM_SEC;
    end else begin
      o_chk_code = `MFD_FS_TLBMISS;
    end
  end

  // highest priority data fault
  always_comb begin
    dom_ok = 1'b1;
    if (i_dabt_align) begin // R11
      dcode = `MFD_FS_ALIGN;
      dom_ok = 1'b0;
    end else if (i_dabt_tlbmiss) begin
      dcode = `MFD_FS_TLBMISS;
      dom_ok = 1'b0;
    end else if (i_dabt_ext_l1) begin
      dcode = `MFD_FS_EXT_L1; // R12
      dom_ok = 1'b0;
    end else if (i_dabt_ext_l2) begin
      dcode = `MFD_FS_EXT_L2; // R12
    end else if (i_dabt_trans) begin
      dcode = i_dabt_page ? `MFD_FS_TR_PAGE : `MFD_FS_TR_SEC; // R10
      dom_ok = i_dabt_page;
    end else if (i_dabt_domain) begin
      dcode = i_dabt_page ? `MFD_FS_DOM_PAGE : `MFD_FS_DOM_SEC; // R10
    end else if (i_dabt_perm) begin
      dcode = i_dabt_page ? `MFD_FS_PERM_PAGE : `MFD_FS_PERM_SEC; // R10
    end else if (i_dabt_ext) begin
      dcode = `MFD_FS_EXT; // R10
    end else begin
      dcode = `MFD_FS_DEBUG; // R13
    end
  end

  wire d_any = i_dabt_align | i_dabt_tlbmiss | i_dabt_ext_l1 | i_dabt_ext_l2 | i_dabt_trans
             | i_dabt_domain | i_dabt_perm | i_dabt_ext | i_dabt_debug;
  wire d_take = i_dabt_take && d_any;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dom_q <= `MFD_RST_REG;
    end else if (wr && sel_dom) begin
      dom_q <= i_cp_wdata; // R1
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_tlb_flush_unlocked <= 1'b0;
    end else begin
      o_tlb_flush_unlocked <= wr && sel_dom; // R6
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      data_fault_cause_q <= `MFD_RST_REG;
    end else if (d_take) begin // R23
      data_fault_cause_q <= {24'h0, dom_ok ? i_dabt_dom : 4'h0, dcode}; // R9
    end else if (wr && sel_fs && !op_i) begin
      data_fault_cause_q <= i_cp_wdata; // R15
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      instruction_fault_cause_q <= `MFD_RST_REG;
    end else if (i_pabt_take) begin // R23
      instruction_fault_cause_q <= {28'h0, i_pabt_debug ? `MFD_FS_DEBUG : i_pabt_code}; // R14
    end else if (wr && sel_fs && op_i) begin
      instruction_fault_cause_q <= i_cp_wdata; // R16
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dfar_q <= `MFD_RST_REG;
    end else if (d_take) begin
      dfar_q <= i_dabt_va; // R21
    end else if (wr && sel_fa && !op_i) begin
      dfar_q <= i_cp_wdata; // R20
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ifar_q <= `MFD_RST_REG;
    end else if (i_pabt_take) begin
      ifar_q <= i_pabt_pc + (i_pabt_narrow ? `MFD_PC_OFS_16 : `MFD_PC_OFS_32); // R22
    end else if (wr && sel_fa && op_i) begin
      ifar_q <= i_cp_wdata; // R20
    end
  end

  // read data registered one cycle after the request
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cp_rdata <= `MFD_RST_REG;
    end else if (i_cp_valid && !i_cp_write) begin
      if (sel_dom) begin
        o_cp_rdata <= dom_q;
      end else if (sel_fs) begin
        o_cp_rdata <= op_i ? instruction_fault_cause_q : data_fault_cause_q; // R15
      end else if (sel_fa) begin
        o_cp_rdata <= op_i ? ifar_q : dfar_q; // R19
      end else begin
        o_cp_rdata <= `MFD_RST_REG;
      end
    end
  end

  a_undef_c4: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_cp_valid && i_cp_crn == 4'h4 |-> o_cp_undef) // R8
    else $error("c4 transfer not undefined");
  a_dom_none: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_chk_valid && dom_q[{i_chk_domain, 1'b0} +: 2] == 2'b00 |-> o_chk_domain_fault && !o_chk_grant) // R2
    else $error("no-access domain not faulted");
  a_dom_client: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_chk_valid && dom_q[{i_chk_domain, 1'b0} +: 2] == 2'b01 |-> o_chk_grant == i_chk_perm_ok) // R3
    else $error("client grant wrong");
  a_dom_rsvd: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_chk_valid && dom_q[{i_chk_domain, 1'b0} +: 2] == 2'b10 |-> o_chk_domain_fault) // R4
    else $error("reserved domain not faulted");
  a_dom_manager: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_chk_valid && dom_q[{i_chk_domain, 1'b0} +: 2] == 2'b11 |-> o_chk_grant && !o_chk_check_perm) // R5
    else $error("manager access not granted");
  a_flush_pulse: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_cp_valid && i_cp_write && i_cp_crn == 4'h3 |=> o_tlb_flush_unlocked) // R6
    else $error("domain write did not flush");
  a_data_fault_cause_align: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_dabt_take && i_dabt_align |=> data_fault_cause_q[3:0] == 4'h1 && data_fault_cause_q[7:4] == 4'h0) // R11
    else $error("alignment not top priority");
  a_data_fault_cause_domain: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_dabt_take && i_dabt_domain && !i_dabt_align && !i_dabt_tlbmiss && !i_dabt_ext_l1
    && !i_dabt_ext_l2 && !i_dabt_trans |=> data_fault_cause_q[7:4] == $past(i_dabt_dom)) // R9
    else $error("domain not recorded");
  a_ext_l1: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_dabt_take && i_dabt_ext_l1 && !i_dabt_align && !i_dabt_tlbmiss |=> data_fault_cause_q[3:0] == 4'hc) // R12
    else $error("first level abort code wrong");
  a_instruction_fault_cause_upper: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_pabt_take |=> instruction_fault_cause_q[31:4] == 28'h0) // R14
    else $error("instruction status upper bits set");
  a_ifar_pc: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_pabt_take && !i_pabt_narrow |=> ifar_q == $past(i_pabt_pc) + 32'h8) // R22
    else $error("instruction address not pc plus 8");
  a_dfar_va: assert property (@(posedge i_clk) disable iff (!i_nrst)
    d_take |=> dfar_q == $past(i_dabt_va)) // R21
    else $error("data fault address not captured");
  a_hold_regs: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_pabt_take && !(i_cp_valid && i_cp_write) |=> $stable(instruction_fault_cause_q) && $stable(ifar_q)) // R23
    else $error("instruction fault state changed");
  a_far_read: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_cp_valid && !i_cp_write && i_cp_crn == 4'h6 && i_cp_op2[0] |=> o_cp_rdata == $past(ifar_q)) // R19
    else $error("fault address read wrong");

  a_undef_other: assert property (@(posedge i_clk) disable iff (!i_nrst) // R8
    i_cp_valid && i_cp_crn != 4'h4
    |-> !o_cp_undef)
    else $error("undefined flag on a mapped register");
  a_undef_nostate: assert property (@(posedge i_clk) disable iff (!i_nrst) // R8
    i_cp_valid && i_cp_write && i_cp_crn == 4'h4 && !i_dabt_take && !i_pabt_take
    |=> $stable(dom_q) && $stable(data_fault_cause_q) && $stable(instruction_fault_cause_q) && $stable(dfar_q) && $stable(ifar_q))
    else $error("register changed by undefined transfer");
  a_dom_write: assert property (@(posedge i_clk) disable iff (!i_nrst) // R1
    i_cp_valid && i_cp_write && i_cp_crn == 4'h3
    |=> dom_q == $past(i_cp_wdata))
    else $error("domain register write lost");
  a_dom_hold: assert property (@(posedge i_clk) disable iff (!i_nrst) // R1
    !(i_cp_valid && i_cp_write && i_cp_crn == 4'h3)
    |=> $stable(dom_q))
    else $error("domain register changed without write");
  a_flush_only: assert property (@(posedge i_clk) disable iff (!i_nrst) // R6
    !(i_cp_valid && i_cp_write && i_cp_crn == 4'h3)
    |=> !o_tlb_flush_unlocked)
    else $error("flush without domain write");
  a_fault_excl: assert property (@(posedge i_clk) disable iff (!i_nrst) // R2
    o_chk_domain_fault
    |-> !o_chk_grant && !o_chk_check_perm)
    else $error("domain fault with grant");
  a_chk_idle: assert property (@(posedge i_clk) disable iff (!i_nrst) // R3
    !i_chk_valid
    |-> !o_chk_domain_fault && !o_chk_grant && !o_chk_check_perm)
    else $error("check output without lookup");
  a_dom_code: assert property (@(posedge i_clk) disable iff (!i_nrst) // R10
    o_chk_domain_fault
    |-> o_chk_code == (i_chk_page ? 4'hb : 4'h9))
    else $error("domain fault code wrong");
  a_perm_code: assert property (@(posedge i_clk) disable iff (!i_nrst) // R10
    o_chk_check_perm && !i_chk_perm_ok
    |-> o_chk_code == (i_chk_page ? 4'hf : 4'hd))
    else $error("permission fault code wrong");
  a_data_fault_cause_upper: assert property (@(posedge i_clk) disable iff (!i_nrst) // R9
    d_take
    |=> data_fault_cause_q[31:8] == 24'h0)
    else $error("data status upper bits set");
  a_tlbmiss: assert property (@(posedge i_clk) disable iff (!i_nrst) // R11
    i_dabt_take && i_dabt_tlbmiss && !i_dabt_align
    |=> data_fault_cause_q[7:0] == 8'h00)
    else $error("tlb miss not second priority");
  a_ext_l2: assert property (@(posedge i_clk) disable iff (!i_nrst) // R12
    i_dabt_take && i_dabt_ext_l2 && !i_dabt_align && !i_dabt_tlbmiss && !i_dabt_ext_l1
    |=> data_fault_cause_q[3:0] == 4'he && data_fault_cause_q[7:4] == $past(i_dabt_dom))
    else $error("second level abort record wrong");
  a_debug_only: assert property (@(posedge i_clk) disable iff (!i_nrst) // R13
    i_dabt_take && i_dabt_debug && !(i_dabt_align || i_dabt_tlbmiss || i_dabt_ext_l1
    || i_dabt_ext_l2 || i_dabt_trans || i_dabt_domain || i_dabt_perm || i_dabt_ext)
    |=> data_fault_cause_q[3:0] == 4'h2)
    else $error("watchpoint code wrong");
  a_data_fault_cause_write: assert property (@(posedge i_clk) disable iff (!i_nrst) // R15
    i_cp_valid && i_cp_write && i_cp_crn == 4'h5 && !i_cp_op2[0] && !i_dabt_take
    |=> data_fault_cause_q == $past(i_cp_wdata))
    else $error("data status write lost");
  a_instruction_fault_cause_write: assert property (@(posedge i_clk) disable iff (!i_nrst) // R16
    i_cp_valid && i_cp_write && i_cp_crn == 4'h5 && i_cp_op2[0] && !i_pabt_take
    |=> instruction_fault_cause_q == $past(i_cp_wdata))
    else $error("instruction status write lost");
  a_instruction_fault_cause_debug: assert property (@(posedge i_clk) disable iff (!i_nrst) // R14
    i_pabt_take && i_pabt_debug
    |=> instruction_fault_cause_q[3:0] == 4'h2)
    else $error("breakpoint code wrong");
  a_instruction_fault_cause_code: assert property (@(posedge i_clk) disable iff (!i_nrst) // R14
    i_pabt_take && !i_pabt_debug
    |=> instruction_fault_cause_q[3:0] == $past(i_pabt_code))
    else $error("prefetch abort code wrong");
  a_ifar_narrow: assert property (@(posedge i_clk) disable iff (!i_nrst) // R22
    i_pabt_take && i_pabt_narrow
    |=> ifar_q == $past(i_pabt_pc) + 32'h4)
    else $error("instruction address not pc plus 4");
  a_dfar_write: assert property (@(posedge i_clk) disable iff (!i_nrst) // R20
    i_cp_valid && i_cp_write && i_cp_crn == 4'h6 && !i_cp_op2[0] && !i_dabt_take
    |=> dfar_q == $past(i_cp_wdata))
    else $error("data address write lost");
  a_ifar_write: assert property (@(posedge i_clk) disable iff (!i_nrst) // R20
    i_cp_valid && i_cp_write && i_cp_crn == 4'h6 && i_cp_op2[0] && !i_pabt_take
    |=> ifar_q == $past(i_cp_wdata))
    else $error("instruction address write lost");
  a_dfar_read: assert property (@(posedge i_clk) disable iff (!i_nrst) // R19
    i_cp_valid && !i_cp_write && i_cp_crn == 4'h6 && !i_cp_op2[0]
    |=> o_cp_rdata == $past(dfar_q))
    else $error("data address read wrong");
  a_data_hold: assert property (@(posedge i_clk) disable iff (!i_nrst) // R23
    !i_dabt_take && !(i_cp_valid && i_cp_write)
    |=> $stable(data_fault_cause_q) && $stable(dfar_q))
    else $error("data fault state changed");
  a_data_fault_cause_read: assert property (@(posedge i_clk) disable iff (!i_nrst) // R15
    i_cp_valid && !i_cp_write && i_cp_crn == 4'h5 && !i_cp_op2[0]
    |=> o_cp_rdata == $past(data_fault_cause_q))
    else $error("data status read wrong");
  a_instruction_fault_cause_read: assert property (@(posedge i_clk) disable iff (!i_nrst) // R16
    i_cp_valid && !i_cp_write && i_cp_crn == 4'h5 && i_cp_op2[0]
    |=> o_cp_rdata == $past(instruction_fault_cause_q))
    else $error("instruction status read wrong");
  a_rdata_hold: assert property (@(posedge i_clk) disable iff (!i_nrst) // R19
    !(i_cp_valid && !i_cp_write)
    |=> $stable(o_cp_rdata))
    else $error("read data changed without read");
  c_dom_write: cover property (@(posedge i_clk) i_cp_valid && i_cp_write && sel_dom);
  c_data_abort: cover property (@(posedge i_clk) d_take && i_dabt_domain);
  c_prefetch: cover property (@(posedge i_clk) i_pabt_take && i_pabt_narrow);
  c_undef: cover property (@(posedge i_clk) o_cp_undef);

endmodule : mfd_regs
`default_nettype wire

// *** verif/mfd_core_model.sv ***
`default_nettype none
module mfd_core_model (
  input wire logic i_clk,
  output logic o_valid,
  output logic o_write,
  output logic [3:0] o_crn,
  output logic [3:0] o_crm,
  output logic [2:0] o_op2,
  output logic [31:0] o_wdata,
  input wire logic [31:0] i_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_crn = 4'h0;
    o_crm = 4'h0;
    o_op2 = 3'h0;
    o_wdata = 32'h0;
  end
  // one transfer; read data taken the cycle after the request edge
  task automatic xfer(input logic w, input logic [3:0] crn, input logic [2:0] op2,
                      input logic [31:0] d, output logic [31:0] q);
    @(negedge i_clk);
    o_valid = 1'b1;
    o_write = w;
    o_crn = crn;
    o_crm = 4'h0;
    o_op2 = op2;
    o_wdata = w ? d : ~o_wdata;
    @(posedge i_clk);
    @(negedge i_clk);
    o_valid = 1'b0;
    o_wdata = ~o_wdata;
    q = i_rdata;
  endtask : xfer
  // status restore: read, then write back with bits 31:8 zero
  task automatic rmw(input logic [3:0] crn, input logic [2:0] op2, input logic [7:0] v);
    logic [31:0] q;
    xfer(1'b0, crn, op2, 32'h0, q);
    xfer(1'b1, crn, op2, {24'h0, (q[7:0] & 8'h00) | v}, q);
  endtask : rmw
endmodule : mfd_core_model
`default_nettype wire

// *** verif/mfd_regs_test.sv ***
`default_nettype none
module mfd_regs_test;
  import mfd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [8:0] FL [12] = '{9'h108, 9'h084, 9'h050, 9'h020, 9'h010, 9'h00e,
                                     9'h004, 9'h003, 9'h001, 9'h010, 9'h004, 9'h008};
  localparam logic [7:0] ST [12] = '{8'h01, 8'h00, 8'h0c, 8'h5e, 8'h57, 8'h5b,
                                     8'h5d, 8'h5a, 8'h52, 8'h05, 8'h5f, 8'h59};
  localparam logic [11:0] PG = 12'h430;
  localparam logic [6:0] CK [5] = '{7'h4b, 7'h2f, 7'h4b, 7'h10, 7'h10};
  logic clk, nrst, valid, write, undef, flush, undef_seen;
  logic cv, cpage, cok, dfault, dchk, dgrant, dtake, dpage, ptake, pdbg, pnar;
  logic [3:0] crn, coprocessor_minor_register_field, cdom, ccode, ddom, pcode;
  logic [2:0] op2;
  logic [8:0] dflags;
  logic [31:0] wdata, rdata, dva, ppc, q;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  mfd_core_model u_core (.i_clk(clk), .o_valid(valid), .o_write(write), .o_crn(crn),
    .o_crm(coprocessor_minor_register_field), .o_op2(op2), .o_wdata(wdata), .i_rdata(rdata));
  mfd_regs u_dut (.i_clk(clk), .i_nrst(nrst), .i_cp_valid(valid), .i_cp_write(write),
    .i_cp_crn(crn), .i_cp_crm(coprocessor_minor_register_field), .i_cp_op2(op2), .i_cp_wdata(wdata),
    .o_cp_rdata(rdata), .o_cp_undef(undef), .i_chk_valid(cv), .i_chk_domain(cdom),
    .i_chk_page(cpage), .i_chk_perm_ok(cok), .o_chk_domain_fault(dfault),
    .o_chk_check_perm(dchk), .o_chk_grant(dgrant), .o_chk_code(ccode),
    .i_dabt_take(dtake), .i_dabt_align(dflags[8]), .i_dabt_tlbmiss(dflags[7]),
    .i_dabt_ext_l1(dflags[6]), .i_dabt_ext_l2(dflags[5]), .i_dabt_trans(dflags[4]),
    .i_dabt_domain(dflags[3]), .i_dabt_perm(dflags[2]), .i_dabt_page(dpage),
    .i_dabt_ext(dflags[1]), .i_dabt_debug(dflags[0]), .i_dabt_dom(ddom), .i_dabt_va(dva),
    .i_pabt_take(ptake), .i_pabt_code(pcode), .i_pabt_debug(pdbg), .i_pabt_pc(ppc),
    .i_pabt_narrow(pnar), .o_tlb_flush_unlocked(flush));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (valid) undef_seen <= undef;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic rd(input logic [3:0] r, input logic [2:0] o, input logic [31:0] exp);
    u_core.xfer(1'b0, r, o, 32'h0, q);
    check("rdata", q, exp);
  endtask : rd
  task automatic wr(input logic [3:0] r, input logic [2:0] o, input logic [31:0] d);
    u_core.xfer(1'b1, r, o, d, q);
  endtask : wr
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  initial begin
    {nrst, cv, cpage, cok, dtake, dpage, ptake, pdbg, pnar} = 9'h0;
    {cdom, ddom, pcode, dflags} = 21'h0;
    {dva, ppc} = 64'h0;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    rd(4'h5, 3'h0, 32'h0);
    $display("test reset done");
    wr(4'h3, 3'h0, 32'hc000_00e4);
    check("flush", flush, 32'h1);
    @(negedge clk);
    check("flush_end", flush, 32'h0);
    rd(4'h3, 3'h0, 32'hc000_00e4);
    cv = 1'b1;
    cpage = 1'b1;
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      cdom = (i == 4) ? 4'hf : 4'(i);
      #1 check("access", {dfault, dchk, dgrant, ccode}, CK[i]);
    end
    @(negedge clk);
    cdom = 4'h1;
    cok = 1'b1;
    #1 check("client_ok", {dfault, dchk, dgrant, ccode}, 7'h30);
    @(negedge clk);
    {cdom, cpage} = 5'h0;
    #1 check("section", {dfault, dchk, dgrant, ccode}, 7'h49);
    $display("test domain done");
    wr(4'h4, 3'h0, 32'hffff_ffff);
    check("undef_wr", undef_seen, 32'h1);
    u_core.xfer(1'b0, 4'h4, 3'h0, 32'h0, q);
    check("undef_rd", undef_seen, 32'h1);
    rd(4'h3, 3'h0, 32'hc000_00e4);
    check("undef_clr", undef_seen, 32'h0);
    $display("test undef done");
    ddom = 4'h5;
    for (int i = 0; i < 12; i++) begin
      @(negedge clk);
      {dtake, dflags, dpage, dva} = {1'b1, FL[i], PG[i], 32'h1000_0000 + 32'(i * 4)};
      @(negedge clk);
      dtake = 1'b0;
      rd(4'h5, 3'h0, {24'h0, ST[i]});
      rd(4'h6, 3'h0, 32'h1000_0000 + 32'(i * 4));
    end
    dflags = 9'h1ff;
    dva = 32'h0;
    repeat (2) @(negedge clk);
    rd(4'h5, 3'h0, 32'h59);
    $display("test data abort done");
    for (int i = 0; i < 2; i++) begin
      @(negedge clk);
      {ptake, pcode, pdbg, ppc, pnar} = {1'b1, 4'hf - 4'(i * 10), 1'(i), 32'h2000, 1'(i)};
      @(negedge clk);
      ptake = 1'b0;
      rd(4'h5, 3'h1, (i == 1) ? 32'h2 : 32'hf);
      rd(4'h6, 3'h1, (i == 1) ? 32'h2004 : 32'h2008);
    end
    $display("test prefetch abort done");
    u_core.rmw(4'h5, 3'h0, 8'ha5);
    rd(4'h5, 3'h0, 32'ha5);
    u_core.rmw(4'h5, 3'h1, 8'h0d);
    rd(4'h5, 3'h1, 32'h0d);
    wr(4'h6, 3'h0, 32'hdead_beef);
    wr(4'h6, 3'h1, 32'h1234_5678);
    rd(4'h6, 3'h0, 32'hdead_beef);
    rd(4'h6, 3'h1, 32'h1234_5678);
    $display("test restore done");
    conclude();
  end
endmodule : mfd_regs_test
`default_nettype wire
